/* rtl/cprc_ctrl.sv */
// Core and peripheral clock/reset control registers behind AXI4-Lite.
// Assumes one system clock, synchronous active-high reset, and a
// master that keeps at most one write and one read outstanding.
//
// Functional notes
// - Second core held in reset while its reset bit is 1.
// - Second core clock stopped while its clock-enable bit is 0.
// - Second core stalled while its stall bit is 1.
// - Boot-address register value becomes the core's ROM boot jump target only while the core is held in reset.
// - All clock-gate and reset bits are active-high levels.
// - Reset bits never self-clear; only software writes clear them.
// - Peripheral clock runs while its gate bit is 1, stops at 0.
// - Peripheral held in reset while its reset bit is 1.
// - Accelerator clock bits: 4 signature, 3 secure boot, 2 RSA, 1 SHA, 0 AES.
// - Accelerator reset bit 4 also resets AES and RSA.
// - Accelerator reset bit 3 also resets AES and SHA.
// - Peripheral clock bits 26 down to 14 map to upper peripherals.
// - Peripheral clock bits 13 down to 0 map to lower peripherals.
// - Peripheral reset bits use the same 27-bit map.
// - Separate radio clock-gate and radio reset registers exist.
//
// The AXI4-Lite interface to the registers was chosen for this implementation.
`timescale 1ns/1ps

module cprc_ctrl
  import cprc_pkg::*;
(
  input  wire logic                            clk,
  input  wire logic                            sys_rst,
  input  wire logic [cprc_pkg::ADDR_W-1:0]     s_axi_awaddr,
  input  wire logic [2:0]                      s_axi_awprot,
  input  wire logic                            s_axi_awvalid,
  output logic                                 s_axi_awready,
  input  wire logic [cprc_pkg::DATA_W-1:0]     s_axi_wdata,
  input  wire logic [cprc_pkg::STRB_W-1:0]     s_axi_wstrb,
  input  wire logic                            s_axi_wvalid,
  output logic                                 s_axi_wready,
  output logic [1:0]                           s_axi_bresp,
  output logic                                 s_axi_bvalid,
  input  wire logic                            s_axi_bready,
  input  wire logic [cprc_pkg::ADDR_W-1:0]     s_axi_araddr,
  input  wire logic [2:0]                      s_axi_arprot,
  input  wire logic                            s_axi_arvalid,
  output logic                                 s_axi_arready,
  output logic [cprc_pkg::DATA_W-1:0]          s_axi_rdata,
  output logic [1:0]                           s_axi_rresp,
  output logic                                 s_axi_rvalid,
  input  wire logic                            s_axi_rready,
  output logic                                 second_core_rst,
  output logic                                 second_core_clk_en,
  output logic                                 second_core_stall,
  output logic [cprc_pkg::DATA_W-1:0]          second_core_boot_addr,
  output logic [cprc_pkg::ACCEL_W-1:0]         accel_clk_en,
  output logic [cprc_pkg::ACCEL_W-1:0]         accel_rst,
  output logic [cprc_pkg::PERIPH_W-1:0]        periph_clk_en,
  output logic [cprc_pkg::PERIPH_W-1:0]        periph_rst,
  output logic [cprc_pkg::DATA_W-1:0]          radio_clk_en,
  output logic [cprc_pkg::DATA_W-1:0]          radio_rst
);

  import cprc_pkg::*;

  // ----------------------------------------------------------------
  // Storage
  // ----------------------------------------------------------------
  logic                aw_hold_q;
  logic                w_hold_q;
  logic [ADDR_W-1:0]   aw_addr_q;
  logic [DATA_W-1:0]   w_data_q;
  logic [STRB_W-1:0]   w_strb_q;
  logic                bvalid_q;
  logic [1:0]          bresp_q;
  logic                rvalid_q;
  logic [1:0]          rresp_q;
  logic [DATA_W-1:0]   rdata_q;
  logic                core_rst_q;
  logic                core_clk_q;
  logic                core_stall_q;
  logic [DATA_W-1:0]   boot_q;
  logic [DATA_W-1:0]   boot_out_q;
  logic [ACCEL_W-1:0]  accel_clk_q;
  logic [ACCEL_W-1:0]  accel_rst_q;
  logic [ACCEL_W-1:0]  accel_rst_out_q;
  logic [ACCEL_W-1:0]  accel_rst_d;
  logic [PERIPH_W-1:0] periph_clk_q;
  logic [PERIPH_W-1:0] periph_rst_q;
  logic [DATA_W-1:0]   radio_clk_q;
  logic [DATA_W-1:0]   radio_rst_q;
  logic                wr_fire;
  logic [3:0]          wr_idx;
  logic [3:0]          rd_idx;
  logic [DATA_W-1:0]   wr_val;
  logic [15:0]         we_vec;
  logic                aw_take;
  logic                w_take;
  logic                ar_take;

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  // Address to register index, IDX_NONE when unmapped
  function automatic logic [3:0] cprc_dec(input logic [ADDR_W-1:0] a);
    logic [3:0] r;
    r = IDX_NONE;
    unique case (a)
      ADDR_ACCEL_CLK:  r = IDX_ACLK;
      ADDR_ACCEL_RST:  r = IDX_ARST;
      ADDR_CORE_RST:   r = IDX_CRST;
      ADDR_CORE_CLK:   r = IDX_CCLK;
      ADDR_CORE_STALL: r = IDX_CSTL;
      ADDR_CORE_BOOT:  r = IDX_CBOOT;
      ADDR_PERIPH_CLK: r = IDX_PCLK;
      ADDR_PERIPH_RST: r = IDX_PRST;
      ADDR_RADIO_CLK:  r = IDX_RCLK;
      ADDR_RADIO_RST:  r = IDX_RRST;
      default:         r = IDX_NONE;
    endcase
    return r;
  endfunction

  // Current word of a register, upper unused bits read zero
  function automatic logic [DATA_W-1:0] cprc_view(input logic [3:0] i);
    logic [DATA_W-1:0] r;
    r = RST_WORD;
    unique case (i)
      IDX_ACLK:  r[ACCEL_W-1:0] = accel_clk_q;
      IDX_ARST:  r[ACCEL_W-1:0] = accel_rst_q;
      IDX_CRST:  r[0] = core_rst_q;
      IDX_CCLK:  r[0] = core_clk_q;
      IDX_CSTL:  r[0] = core_stall_q;
      IDX_CBOOT: r = boot_q;
      IDX_PCLK:  r[PERIPH_W-1:0] = periph_clk_q;
      IDX_PRST:  r[PERIPH_W-1:0] = periph_rst_q;
      IDX_RCLK:  r = radio_clk_q;
      IDX_RRST:  r = radio_rst_q;
      default:   r = RST_WORD;
    endcase
    return r;
  endfunction

  // Byte-lane merge of new data over old word
  function automatic logic [DATA_W-1:0] cprc_merge(
    input logic [DATA_W-1:0] old_w,
    input logic [DATA_W-1:0] new_w,
    input logic [STRB_W-1:0] strb);
    logic [DATA_W-1:0] r;
    r = old_w;
    for (int i = 0; i < STRB_W; i++) begin
      if (strb[i]) begin
        r[8*i +: 8] = new_w[8*i +: 8];
      end
    end
    return r;
  endfunction

  // ----------------------------------------------------------------
  // Write channel
  // ----------------------------------------------------------------
  // Address and data taken in either order, one write in flight
  assign s_axi_awready = !aw_hold_q && !bvalid_q;
  assign s_axi_wready  = !w_hold_q && !bvalid_q;
  assign aw_take = s_axi_awvalid && s_axi_awready;
  assign w_take  = s_axi_wvalid && s_axi_wready;
  assign wr_fire = aw_hold_q && w_hold_q && !bvalid_q;
  assign wr_idx  = cprc_dec(aw_addr_q);
  assign wr_val  = cprc_merge(cprc_view(wr_idx), w_data_q, w_strb_q);
  assign we_vec  = wr_fire ? (16'h0001 << wr_idx) : 16'h0000;

  // Address hold
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      aw_hold_q <= 1'b0;
      aw_addr_q <= RST_WORD;
    end else if (aw_take) begin
      aw_hold_q <= 1'b1;
      aw_addr_q <= s_axi_awaddr;
    end else if (wr_fire) begin
      aw_hold_q <= 1'b0;
    end
  end

  // Data hold
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      w_hold_q <= 1'b0;
      w_data_q <= RST_WORD;
      w_strb_q <= 4'h0;
    end else if (w_take) begin
      w_hold_q <= 1'b1;
      w_data_q <= s_axi_wdata;
      w_strb_q <= s_axi_wstrb;
    end else if (wr_fire) begin
      w_hold_q <= 1'b0;
    end
  end

  // Write response, error for an unmapped address
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      bvalid_q <= 1'b0;
      bresp_q  <= RESP_OKAY;
    end else if (wr_fire) begin
      bvalid_q <= 1'b1;
      bresp_q  <= (wr_idx == IDX_NONE) ? RESP_SLVERR : RESP_OKAY;
    end else if (s_axi_bready) begin
      bvalid_q <= 1'b0;
    end
  end

  assign s_axi_bvalid = bvalid_q;
  assign s_axi_bresp  = bresp_q;

  // ----------------------------------------------------------------
  // Read channel
  // ----------------------------------------------------------------
  assign s_axi_arready = !rvalid_q;
  assign ar_take = s_axi_arvalid && s_axi_arready;
  assign rd_idx  = cprc_dec(s_axi_araddr);

  // Read data captured at address acceptance
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      rvalid_q <= 1'b0;
      rresp_q  <= RESP_OKAY;
      rdata_q  <= RST_WORD;
    end else if (ar_take) begin
      rvalid_q <= 1'b1;
      rresp_q  <= (rd_idx == IDX_NONE) ? RESP_SLVERR : RESP_OKAY;
      rdata_q  <= cprc_view(rd_idx);
    end else if (s_axi_rready) begin
      rvalid_q <= 1'b0;
    end
  end

  assign s_axi_rvalid = rvalid_q;
  assign s_axi_rresp  = rresp_q;
  assign s_axi_rdata  = rdata_q;

  // ----------------------------------------------------------------
  // Second core control
  // ----------------------------------------------------------------
  // reset, clock gate, stall bits
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      core_rst_q   <= RST_CORE_RST;
      core_clk_q   <= RST_CORE_CLK;
      core_stall_q <= RST_CORE_STALL;
    end else begin
      if (we_vec[IDX_CRST]) begin
        core_rst_q <= wr_val[0];
      end
      if (we_vec[IDX_CCLK]) begin
        core_clk_q <= wr_val[0];
      end
      if (we_vec[IDX_CSTL]) begin
        core_stall_q <= wr_val[0];
      end
    end
  end

  // Boot address register
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      boot_q <= RST_WORD;
    end else if (we_vec[IDX_CBOOT]) begin
      boot_q <= wr_val;
    end
  end

  // boot target follows only while core is in reset
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      boot_out_q <= RST_WORD;
    end else if (core_rst_q) begin
      boot_out_q <= boot_q;
    end
  end

  assign second_core_rst       = core_rst_q;
  assign second_core_clk_en    = core_clk_q;
  assign second_core_stall     = core_stall_q;
  // jump target presented to the core
  assign second_core_boot_addr = boot_out_q;

  // ----------------------------------------------------------------
  // Accelerator gates and resets
  // ----------------------------------------------------------------
  // accelerator clock and reset bits
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      accel_clk_q <= RST_WORD[ACCEL_W-1:0];
      accel_rst_q <= RST_WORD[ACCEL_W-1:0];
    end else begin
      if (we_vec[IDX_ACLK]) begin
        accel_clk_q <= wr_val[ACCEL_W-1:0];
      end
      // reset bits change only on a write
      if (we_vec[IDX_ARST]) begin
        accel_rst_q <= wr_val[ACCEL_W-1:0];
      end
    end
  end

  // signature reset also hits AES and RSA
  // secure-boot reset also hits AES and SHA
  always_comb begin
    accel_rst_d = accel_rst_q;
    accel_rst_d[ACC_AES] = accel_rst_q[ACC_AES] | accel_rst_q[ACC_DSIG]
                         | accel_rst_q[ACC_SBOOT];
    accel_rst_d[ACC_RSA] = accel_rst_q[ACC_RSA] | accel_rst_q[ACC_DSIG];
    accel_rst_d[ACC_SHA] = accel_rst_q[ACC_SHA] | accel_rst_q[ACC_SBOOT];
  end

  // Registered fan-out keeps the reset outputs glitch free
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      accel_rst_out_q <= RST_WORD[ACCEL_W-1:0];
    end else begin
      accel_rst_out_q <= accel_rst_d;
    end
  end

  assign accel_clk_en = accel_clk_q;
  assign accel_rst    = accel_rst_out_q;

  // ----------------------------------------------------------------
  // Peripheral and radio gates and resets
  // ----------------------------------------------------------------
  // one bit per peripheral in the clock gate
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      periph_clk_q <= RST_WORD[PERIPH_W-1:0];
      periph_rst_q <= RST_WORD[PERIPH_W-1:0];
    end else begin
      if (we_vec[IDX_PCLK]) begin
        periph_clk_q <= wr_val[PERIPH_W-1:0];
      end
      // reset uses the same bit map
      if (we_vec[IDX_PRST]) begin
        periph_rst_q <= wr_val[PERIPH_W-1:0];
      end
    end
  end

  // separate radio gate and reset words
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      radio_clk_q <= RST_WORD;
      radio_rst_q <= RST_WORD;
    end else begin
      if (we_vec[IDX_RCLK]) begin
        radio_clk_q <= wr_val;
      end
      if (we_vec[IDX_RRST]) begin
        radio_rst_q <= wr_val;
      end
    end
  end

  // enables and resets out as levels
  // low peripheral bits share the same path
  assign periph_clk_en = periph_clk_q;
  assign periph_rst    = periph_rst_q;
  assign radio_clk_en  = radio_clk_q;
  assign radio_rst     = radio_rst_q;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (sys_rst);

  // Core reset follows the written bit
  core_reset_a: assert property (
    we_vec[IDX_CRST] |=> second_core_rst == $past(wr_val[0]))
    else $error("core reset does not follow write");

  // Core clock enable follows the written bit
  core_clock_a: assert property (
    we_vec[IDX_CCLK] |=> second_core_clk_en == $past(wr_val[0]))
    else $error("core clock enable does not follow write");

  // Stall follows the written bit
  core_stall_a: assert property (
    we_vec[IDX_CSTL] |=> second_core_stall == $past(wr_val[0]))
    else $error("core stall does not follow write");

  // Jump target loaded while core held in reset
  boot_load_a: assert property (
    second_core_rst |=> second_core_boot_addr == $past(boot_q))
    else $error("boot target not loaded during reset");

  // Jump target frozen once core runs
  boot_hold_a: assert property (
    !second_core_rst |=> $stable(second_core_boot_addr))
    else $error("boot target moved while core runs");

  // Peripheral reset never clears without a write
  reset_sticky_a: assert property (
    !we_vec[IDX_PRST] |=> $stable(periph_rst))
    else $error("peripheral reset changed without write");

  // Peripheral clock gate follows written value
  periph_clock_a: assert property (
    we_vec[IDX_PCLK] |=> periph_clk_en == $past(wr_val[PERIPH_W-1:0]))
    else $error("peripheral clock gate wrong");

  // Signature reset fans to AES and RSA
  dsig_fanout_a: assert property (
    accel_rst_q[ACC_DSIG] |=> accel_rst[ACC_AES] && accel_rst[ACC_RSA]
                              && accel_rst[ACC_DSIG])
    else $error("signature reset fan-out missing");

  // Secure-boot reset fans to AES and SHA
  sboot_fanout_a: assert property (
    accel_rst_q[ACC_SBOOT] |=> accel_rst[ACC_AES] && accel_rst[ACC_SHA]
                               && accel_rst[ACC_SBOOT])
    else $error("secure boot reset fan-out missing");

  // Write answer one cycle after both halves held
  write_resp_a: assert property (
    wr_fire |=> s_axi_bvalid)
    else $error("write response timing wrong");

  // Write answer held until taken
  write_hold_a: assert property (
    s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write answer dropped early");

  // Read answer held until taken
  read_hold_a: assert property (
    s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read answer dropped early");

  // Main scenarios
  release_core_c: cover property (
    second_core_rst ##1 !second_core_rst);
  unmapped_wr_c: cover property (
    s_axi_bvalid && s_axi_bresp == RESP_SLVERR);
  boot_read_c: cover property (
    ar_take && rd_idx == IDX_CBOOT);

endmodule

/* shared/cprc_pkg.sv */
// Package for the core and peripheral clock/reset control block.
// Assumes a 32-bit AXI4-Lite register port and a single system clock.
package cprc_pkg;

  // ----------------------------------------------------------------
  // Bus widths
  // ----------------------------------------------------------------
  localparam int ADDR_W = 32;
  localparam int DATA_W = 32;
  localparam int STRB_W = 4;

  // ----------------------------------------------------------------
  // Register byte addresses
  // ----------------------------------------------------------------
  localparam logic [31:0] ADDR_ACCEL_CLK  = 32'h3FF0_001C;
  localparam logic [31:0] ADDR_ACCEL_RST  = 32'h3FF0_0020;
  localparam logic [31:0] ADDR_CORE_RST   = 32'h3FF0_002C;
  localparam logic [31:0] ADDR_CORE_CLK   = 32'h3FF0_0030;
  localparam logic [31:0] ADDR_CORE_STALL = 32'h3FF0_0034;
  localparam logic [31:0] ADDR_CORE_BOOT  = 32'h3FF0_0038;
  localparam logic [31:0] ADDR_PERIPH_CLK = 32'h3FF0_00C0;
  localparam logic [31:0] ADDR_PERIPH_RST = 32'h3FF0_00C4;
  localparam logic [31:0] ADDR_RADIO_CLK  = 32'h3FF0_00CC;
  localparam logic [31:0] ADDR_RADIO_RST  = 32'h3FF0_00D0;

  // ----------------------------------------------------------------
  // Register indices after decode
  // ----------------------------------------------------------------
  localparam logic [3:0] IDX_ACLK  = 4'h0;
  localparam logic [3:0] IDX_ARST  = 4'h1;
  localparam logic [3:0] IDX_CRST  = 4'h2;
  localparam logic [3:0] IDX_CCLK  = 4'h3;
  localparam logic [3:0] IDX_CSTL  = 4'h4;
  localparam logic [3:0] IDX_CBOOT = 4'h5;
  localparam logic [3:0] IDX_PCLK  = 4'h6;
  localparam logic [3:0] IDX_PRST  = 4'h7;
  localparam logic [3:0] IDX_RCLK  = 4'h8;
  localparam logic [3:0] IDX_RRST  = 4'h9;
  localparam logic [3:0] IDX_NONE  = 4'hF;

  // ----------------------------------------------------------------
  // Field widths and accelerator bit positions
  // ----------------------------------------------------------------
  localparam int ACCEL_W  = 5;
  localparam int PERIPH_W = 27;
  localparam int ACC_AES  = 0;
  localparam int ACC_SHA  = 1;
  localparam int ACC_RSA  = 2;
  localparam int ACC_SBOOT = 3;
  localparam int ACC_DSIG = 4;

  // ----------------------------------------------------------------
  // Peripheral bit positions (clock gate and reset alike)
  // ----------------------------------------------------------------
  localparam int P_PWM3 = 26;
  localparam int P_PWM2 = 25;
  localparam int P_UART_MEM = 24;
  localparam int P_UART2 = 23;
  localparam int P_SPI_DMA = 22;
  localparam int P_I2S1 = 21;
  localparam int P_PWM1 = 20;
  localparam int P_CAN = 19;
  localparam int P_I2C1 = 18;
  localparam int P_PWM0 = 17;
  localparam int P_SPI3 = 16;
  localparam int P_TIMG1 = 15;
  localparam int P_FUSE = 14;
  localparam int P_TIMG0 = 13;
  localparam int P_HOST_DMA1 = 12;
  localparam int P_LED_DIM = 11;
  localparam int P_PULSE_COUNTER_UNIT = 10;
  localparam int P_REMOTE = 9;
  localparam int P_HOST_DMA0 = 8;
  localparam int P_I2C0 = 7;
  localparam int P_SPI2 = 6;
  localparam int P_UART1 = 5;
  localparam int P_I2S0 = 4;
  localparam int P_WATCHDOG = 3;
  localparam int P_UART0 = 2;
  localparam int P_SPI1 = 1;
  localparam int P_TIMERS = 0;

  // ----------------------------------------------------------------
  // Reset values and bus responses
  // ----------------------------------------------------------------
  localparam logic        RST_CORE_RST   = 1'h1;
  localparam logic        RST_CORE_CLK   = 1'h0;
  localparam logic        RST_CORE_STALL = 1'h0;
  localparam logic [31:0] RST_WORD       = 32'h0000_0000;
  localparam logic [1:0]  RESP_OKAY      = 2'h0;
  localparam logic [1:0]  RESP_SLVERR    = 2'h2;

endpackage

/* verification/cprc_core_model.sv */
// Behavioural model of the second core on the far side.
// Assumes level controls from cprc_ctrl on the one system clock.
`timescale 1ns/1ps
module cprc_core_model (
  input  wire logic        clk,
  input  wire logic        core_rst,
  input  wire logic        core_clk_en,
  input  wire logic        core_stall,
  input  wire logic [31:0] boot_addr,
  output logic [31:0]      jump_addr_q,
  output logic [31:0]      steps_q
);
  // held in reset, jump target sampled
  always_ff @(posedge clk) begin
    if (core_rst) begin
      jump_addr_q <= boot_addr;
      steps_q     <= 32'h0;
    end else if (core_clk_en && !core_stall) begin
      steps_q <= steps_q + 32'h1;
    end
  end
endmodule

/* verification/tb.sv */
// Self-checking bench for cprc_ctrl with a second-core model.
// Assumes cprc_pkg and cprc_core_model are compiled first.
`timescale 1ns/1ps
module tb;
  import cprc_pkg::*;
  logic        clk, sys_rst, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid;
  logic        s_axi_rready, second_core_rst, second_core_clk_en, second_core_stall;
  logic [31:0] s_axi_awaddr, s_axi_wdata, s_axi_araddr, s_axi_rdata, radio_clk_en;
  logic [31:0] radio_rst, second_core_boot_addr, jump_addr, steps, rd, v, boot;
  logic [2:0]  s_axi_awprot, s_axi_arprot;
  logic [3:0]  s_axi_wstrb;
  logic [1:0]  s_axi_bresp, s_axi_rresp, rsp;
  logic [4:0]  accel_clk_en, accel_rst;
  logic [26:0] periph_clk_en, periph_rst;
  int          failures = 0, n_compared = 0, cyc = 0;

  cprc_ctrl i_dut (.clk, .sys_rst, .s_axi_awaddr, .s_axi_awprot, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
    .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arprot, .s_axi_arvalid,
    .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
    .second_core_rst, .second_core_clk_en, .second_core_stall, .second_core_boot_addr,
    .accel_clk_en, .accel_rst, .periph_clk_en, .periph_rst, .radio_clk_en, .radio_rst);
  cprc_core_model i_core (.clk, .core_rst(second_core_rst), .core_clk_en(second_core_clk_en),
    .core_stall(second_core_stall), .boot_addr(second_core_boot_addr),
    .jump_addr_q(jump_addr), .steps_q(steps));

  // Clock and hang guard
  always #25 clk = ~clk;
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      failures++;
      final_report();
    end
  end

  // ----
  // Helpers
  // ----
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      failures++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic final_report();
    $display("compared=%0d failures=%0d", n_compared, failures);
    if (failures == 0 && n_compared > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  // Write one word, wait for the response
  task automatic wr(input logic [31:0] a, input logic [31:0] d, input logic [3:0] s);
    logic ta, tw, tr, bv;
    @(posedge clk);
    s_axi_bready <= 1'($urandom());
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_wstrb <= s;
    s_axi_awvalid <= 1'h1;
    s_axi_wvalid <= 1'h1;
    do begin
      @(negedge clk);
      ta = s_axi_awvalid & s_axi_awready;
      tw = s_axi_wvalid & s_axi_wready;
      bv = s_axi_bvalid;
      tr = bv & s_axi_bready;
      rsp = s_axi_bresp;
      @(posedge clk);
      if (ta) s_axi_awvalid <= 1'h0;
      if (tw) s_axi_wvalid <= 1'h0;
      if (bv) s_axi_bready <= 1'h1;
    end while (!tr);
  endtask
  // Read one word into rd and rsp
  task automatic rdr(input logic [31:0] a);
    logic ta, tr, rv;
    @(posedge clk);
    s_axi_rready <= 1'($urandom());
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'h1;
    do begin
      @(negedge clk);
      ta = s_axi_arvalid & s_axi_arready;
      rv = s_axi_rvalid;
      tr = rv & s_axi_rready;
      rd = s_axi_rdata;
      rsp = s_axi_rresp;
      @(posedge clk);
      if (ta) s_axi_arvalid <= 1'h0;
      if (rv) s_axi_rready <= 1'h1;
    end while (!tr);
  endtask
  // Count core steps over four cycles
  task automatic runs(input logic [31:0] exp);
    @(negedge clk);
    v = steps;
    repeat (4) @(negedge clk);
    chk(steps - v, exp);
  endtask
  // Expected accelerator reset fan-out
  function automatic logic [4:0] acc_exp(input logic [4:0] r);
    return {r[4], r[3], r[2] | r[4], r[1] | r[3], r[0] | r[3] | r[4]};
  endfunction

  // ----
  // Main sequence
  // ----
  initial begin
    clk = 1'h0;
    sys_rst = 1'h1;
    {s_axi_awvalid, s_axi_wvalid, s_axi_arvalid, s_axi_awprot, s_axi_arprot} = '0;
    {s_axi_awaddr, s_axi_wdata, s_axi_araddr, s_axi_wstrb} = '0;
    s_axi_bready = 1'h1;
    s_axi_rready = 1'h1;
    v = $urandom(32'h30CD);
    repeat (3) @(posedge clk);
    sys_rst <= 1'h0;
    @(negedge clk);
    chk({29'h0, second_core_rst, second_core_clk_en, second_core_stall}, 32'h4);
    chk({accel_rst, periph_rst}, 32'h0);
    chk({5'h0, periph_clk_en}, 32'h0);
    rdr(ADDR_CORE_RST);
    chk(rd, 32'h1);
    boot = $urandom();
    wr(ADDR_CORE_BOOT, boot, 4'hF);
    wr(ADDR_CORE_CLK, 32'h1, 4'hF);
    wr(ADDR_CORE_RST, 32'h0, 4'hF);
    chk({30'h0, rsp}, {30'h0, RESP_OKAY});
    wr(ADDR_CORE_BOOT, ~boot, 4'hF);
    rdr(ADDR_CORE_BOOT);
    @(negedge clk);
    chk(jump_addr, boot);
    chk(second_core_boot_addr, boot);
    chk(rd, ~boot);
    runs(32'h4);
    wr(ADDR_CORE_STALL, 32'h1, 4'hF);
    runs(32'h0);
    wr(ADDR_CORE_STALL, 32'h0, 4'hF);
    wr(ADDR_CORE_CLK, 32'h0, 4'hF);
    runs(32'h0);
    wr(ADDR_CORE_RST, 32'h1, 4'hF);
    repeat (2) @(negedge clk);
    chk({31'h0, second_core_rst}, 32'h1);
    chk(second_core_boot_addr, ~boot);
    for (int i = 0; i < 8; i++) begin
      v = (i == 0) ? 32'hFFFF_FFFF : $urandom();
      v[P_UART_MEM] = v[P_UART_MEM] | v[P_UART2] | v[P_UART1] | v[P_UART0];
      wr(ADDR_PERIPH_CLK, v, 4'hF);
      wr(ADDR_PERIPH_RST, ~v, 4'hF);
      wr(ADDR_RADIO_CLK, v, 4'hF);
      wr(ADDR_RADIO_RST, ~v, 4'hF);
      repeat (2) @(negedge clk);
      chk({5'h0, periph_clk_en}, {5'h0, v[26:0]});
      chk({5'h0, periph_rst}, {5'h0, ~v[26:0]});
      chk(radio_clk_en ^ radio_rst, 32'hFFFF_FFFF);
      rdr(ADDR_PERIPH_RST);
      chk(rd, {5'h0, ~v[26:0]});
    end
    for (int i = 0; i < 32; i++) begin
      wr(ADDR_ACCEL_CLK, 32'(i), 4'hF);
      wr(ADDR_ACCEL_RST, 32'(i), 4'hF);
      repeat (2) @(negedge clk);
      chk({27'h0, accel_clk_en}, {27'h0, i[4:0]});
      chk({27'h0, accel_rst}, {27'h0, acc_exp(i[4:0])});
    end
    repeat (20) @(negedge clk);
    chk({27'h0, accel_rst}, 32'h1F);
    wr(ADDR_RADIO_CLK, 32'hA5A5_A5A5, 4'h5);
    rdr(ADDR_RADIO_CLK);
    chk(rd, {v[31:24], 8'hA5, v[15:8], 8'hA5});
    wr(32'h3FF0_00C8, 32'hFFFF_FFFF, 4'hF);
    chk({30'h0, rsp}, {30'h0, RESP_SLVERR});
    rdr(32'h3FF0_00C8);
    chk({rsp, rd[29:0]}, {RESP_SLVERR, 30'h0});
    final_report();
  end
endmodule
